// *** dv/motor_side.sv ***
// model of the status monitoring and thermal stages feeding the guard
// assumes the bench calls its tasks between clock edges
`timescale 1ns/1ps
module motor_side (
   input wire ref_clk,
   output reg motor_start_detect,
   output reg thermal_overload_stage,
   output reg [9:0] theta_used
);
   initial begin
      motor_start_detect = 1'b0;
      thermal_overload_stage = 1'b0;
      theta_used = 10'h000;
   end
   // one-cycle start pulse per attempt
   task fire;
      begin
         @(posedge ref_clk);
         #1 motor_start_detect = 1'b1;
         @(posedge ref_clk);
         #1 motor_start_detect = 1'b0;
      end
   endtask
   task heat(input reg on, input reg [9:0] th);
      begin
         @(posedge ref_clk);
         #1 thermal_overload_stage = on;
         theta_used = th;
      end
   endtask
endmodule

// *** dv/start_guard_monitor.sv ***
// assertions on the guard outputs
// assumes ce held high and event selections steady
`timescale 1ns/1ps
module start_guard_monitor #(
   parameter CNT_W = 40,
   parameter TICK_DIV = 2000000,
   parameter TENTHS_PER_HOUR = 36000
) (
   input wire ref_clk,
   input wire srst,
   input wire block_in,
   input wire [2:0] ev_sel_on,
   input wire [2:0] ev_sel_off,
   input wire alarm,
   input wire inhibit,
   input wire blocked,
   input wire [2:0] mode,
   input wire [6:0] starts_avail,
   input wire ev_valid,
   input wire [2:0] ev_code,
   input wire ev_store,
   input wire [3:0] log_count
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence s_alarm_ev;
      ##[0:2] ev_valid && ev_code == 3'h0;
   endsequence
   sequence s_inh_ev;
      ##[0:2] ev_valid && ev_code == 3'h2;
   endsequence
   chk_alarm_one_left: assert property (alarm |-> starts_avail == 7'h01)
      else $error("alarm without exactly one start left");
   chk_inhibit_release: assert property ($fell(inhibit) && (mode == 3'h0 || mode == 3'h2)
      |-> starts_avail != 7'h00)
      else $error("inhibit dropped with no start left");
   chk_reset_mode_on: assert property ($fell(srst) |-> mode == 3'h0 && !alarm)
      else $error("mode not on after reset");
   chk_blocked_mode: assert property ((mode == 3'h1 || mode == 3'h3)[*3] |-> blocked)
      else $error("blocked low in a blocking mode");
   chk_off_unblocked: assert property ((mode == 3'h4 && !block_in)[*3] |-> !blocked)
      else $error("blocked high while off");
   chk_refused_low: assert property ((mode == 3'h1 || mode == 3'h3 || mode == 3'h4)[*3]
      |-> !alarm && !inhibit)
      else $error("alarm or inhibit in a refusing mode");
   chk_event_store: assert property (ev_valid |-> ev_store ==
      (ev_code[0] ? ev_sel_off[ev_code[2:1]] : ev_sel_on[ev_code[2:1]]))
      else $error("store flag disagrees with selection");
   chk_alarm_event: assert property ($rose(alarm) |-> s_alarm_ev)
      else $error("no alarm on event");
   chk_inhibit_event: assert property ($rose(inhibit) && $stable(alarm) |-> s_inh_ev)
      else $error("no inhibit on event");
   chk_log_full_holds: assert property (log_count == 4'hC |=> log_count == 4'hC)
      else $error("log count left twelve");
endmodule
bind start_guard start_guard_monitor #(.CNT_W(CNT_W), .TICK_DIV(TICK_DIV),
   .TENTHS_PER_HOUR(TENTHS_PER_HOUR)) start_guard_monitor_i (.ref_clk(ref_clk),
   .srst(srst), .block_in(block_in), .ev_sel_on(ev_sel_on), .ev_sel_off(ev_sel_off),
   .alarm(alarm), .inhibit(inhibit), .blocked(blocked), .mode(mode),
   .starts_avail(starts_avail), .ev_valid(ev_valid), .ev_code(ev_code),
   .ev_store(ev_store), .log_count(log_count));

// *** dv/test_start_guard.sv ***
// self-checking bench for the frequent-start guard
// assumes a shortened 0.1 s tick and a one-hour window of 36 ticks
`timescale 1ns/1ps
module test_start_guard;
   localparam TD = 1000;
   reg ref_clk = 1'b0;
   reg srst = 1'b1;
   reg hot_cold_en = 1'b0;
   reg [9:0] hot_limit = 10'h2BC;
   reg [6:0] starts_cold = 7'h03;
   reg [6:0] starts_hot = 7'h02;
   reg [12:0] min_gap = 13'h0001;
   reg stall_cold_set = 1'b1;
   reg mode_wr = 1'b0;
   reg [2:0] mode_in = 3'h0;
   reg block_in = 1'b0;
   reg [2:0] ev_sel_on = 3'h7;
   reg [2:0] ev_sel_off = 3'h5;
   reg [47:0] time_stamp = 48'h0;
   reg [3:0] log_rd_idx = 4'h0;
   reg [2:0] last_code = 3'h7;
   reg [47:0] last_stamp = 48'h0;
   integer error_cnt = 0;
   integer check_count = 0;
   integer n;
   wire motor_start_detect, thermal_overload_stage, alarm, inhibit, blocked, hot_state;
   wire ev_valid, ev_store;
   wire [9:0] theta_used;
   wire [2:0] mode, ev_code, log_rd_event;
   wire [6:0] starts_used, starts_avail, log_rd_count;
   wire [47:0] ev_stamp, log_rd_stamp;
   wire [31:0] log_rd_inh_dur, log_rd_since;
   wire [3:0] log_count;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      time_stamp <= time_stamp + 48'h1;
      if (ev_valid === 1'b1) begin
         last_code <= ev_code;
         last_stamp <= ev_stamp;
      end
   end
   motor_side motor_side_i (.ref_clk(ref_clk), .motor_start_detect(motor_start_detect),
      .thermal_overload_stage(thermal_overload_stage), .theta_used(theta_used));
   start_guard #(.TICK_DIV(TD), .TENTHS_PER_HOUR(36)) start_guard_i (.ref_clk(ref_clk),
      .srst(srst), .ce(1'b1), .motor_start_detect(motor_start_detect),
      .thermal_overload_stage(thermal_overload_stage), .theta_used(theta_used),
      .hot_cold_en(hot_cold_en), .hot_limit(hot_limit), .stall_cold(13'h00C8),
      .stall_cold_set(stall_cold_set), .stall_hot(13'h0096), .starts_cold(starts_cold),
      .starts_hot(starts_hot), .win_hours(7'h01), .min_gap(min_gap), .mode_wr(mode_wr),
      .mode_in(mode_in), .block_in(block_in), .ev_sel_on(ev_sel_on),
      .ev_sel_off(ev_sel_off), .time_stamp(time_stamp), .log_rd_idx(log_rd_idx),
      .alarm(alarm), .inhibit(inhibit), .blocked(blocked), .mode(mode),
      .hot_state(hot_state), .starts_used(starts_used), .starts_avail(starts_avail),
      .ev_valid(ev_valid), .ev_code(ev_code), .ev_stamp(ev_stamp), .ev_store(ev_store),
      .log_count(log_count), .log_rd_stamp(log_rd_stamp), .log_rd_event(log_rd_event),
      .log_rd_inh_dur(log_rd_inh_dur), .log_rd_since(log_rd_since),
      .log_rd_count(log_rd_count));
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", check_count, error_cnt);
         if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task check(input string what, input [47:0] exp, input [47:0] got);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
         end
      end
   endtask
   // every drive lands 1 ns after an edge
   task step(input integer k);
      begin
         repeat (k) @(posedge ref_clk);
         #1;
      end
   endtask
   task do_reset;
      begin
         srst = 1'b1;
         step(20);
         srst = 1'b0;
      end
   endtask
   task set_mode(input [2:0] m);
      begin
         mode_in = m;
         mode_wr = 1'b1;
         step(1);
         mode_wr = 1'b0;
         step(4);
      end
   endtask
   task cold_starts;
      begin
         do_reset;
         check("mode", 3'h0, mode);
         motor_side_i.fire;
         step(4);
         check("used", 1, starts_used);
         check("gap_inhibit", 1, inhibit);
         motor_side_i.fire;
         step(4);
         check("alarm", 1, alarm);
         motor_side_i.fire;
         step(4);
         check("avail", 0, starts_avail);
         check("inhibit", 1, inhibit);
         n = 0;
         while (inhibit === 1'b1 && n < 20 * TD) begin
            step(1);
            n = n + 1;
         end
         if (n >= 20 * TD) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
         end
         // draining one of three starts takes a third of the window
         check("hold_long", 1, n > 8 * TD);
         check("avail_back", 1, starts_avail);
         // alarm on and inhibit off meet; the alarm record wins, a third of 36 ticks in
         step(3);
         check("log_since", 12, log_rd_since);
         check("log_inh_dur", 12, log_rd_inh_dur);
         check("log_alarm_ev", 0, log_rd_event);
         check("log_used", 2, log_rd_count);
      end
   endtask
   task hot_starts;
      begin
         do_reset;
         hot_cold_en = 1'b1;
         hot_limit = 10'h190;
         motor_side_i.heat(1'b1, 10'h191);
         step(4);
         check("hot", 1, hot_state);
         motor_side_i.fire;
         step(4);
         check("hot_alarm", 1, alarm);
         motor_side_i.heat(1'b1, 10'h190);
         step(4);
         check("cold_avail", 2, starts_avail);
         motor_side_i.heat(1'b0, 10'h3E7);
         step(4);
         check("stage_off", 0, hot_state);
         // cold start weighed with the hot stall time fills exactly one hot start
         do_reset;
         stall_cold_set = 1'b0;
         motor_side_i.fire;
         step(4);
         motor_side_i.heat(1'b1, 10'h191);
         step(4);
         check("fallback_avail", 1, starts_avail);
         stall_cold_set = 1'b1;
         motor_side_i.heat(1'b0, 10'h000);
         hot_cold_en = 1'b0;
         hot_limit = 10'h2BC;
      end
   endtask
   task modes_and_log;
      begin
         do_reset;
         set_mode(3'h1);
         check("blocked", 1, blocked);
         check("ev_code", 3'h4, last_code);
         check("stamp_age", 1, time_stamp - last_stamp < 8);
         motor_side_i.fire;
         step(4);
         check("blk_used", 0, starts_used);
         set_mode(3'h5);
         check("bad_mode", 3'h1, mode);
         set_mode(3'h3);
         check("tb_mode", 3'h3, mode);
         set_mode(3'h4);
         check("off_blk", 0, blocked);
         set_mode(3'h0);
         block_in = 1'b1;
         step(4);
         check("ext_blk", 1, blocked);
         block_in = 1'b0;
         for (n = 0; n < 6; n = n + 1) begin
            set_mode(3'h1);
            set_mode(3'h0);
         end
         check("log_full", 4'hC, log_count);
         check("log_ev", 3'h5, log_rd_event);
         check("log_cnt", 0, log_rd_count);
         check("log_stamp", last_stamp, log_rd_stamp);
         log_rd_idx = 4'h1;
         step(1);
         check("log_prev", 3'h4, log_rd_event);
         set_mode(3'h2);
         motor_side_i.fire;
         step(4);
         check("test_used", 1, starts_used);
      end
   endtask
   initial begin
      cold_starts;
      hot_starts;
      modes_and_log;
      report_and_stop;
   end
endmodule

// *** hw/edge_events.v ***
// turns three status levels into six on/off event pulses with a filter
// assumes levels are registered and event selections are steady
`timescale 1ns/1ps
`include "start_guard_map.vh"
module edge_events (
   input wire ref_clk,
   input wire srst,
   input wire ce,
   input wire [2:0] lvl,
   input wire [2:0] sel_on,
   input wire [2:0] sel_off,
   output reg [5:0] ev,
   output reg [5:0] ev_store
);
   reg [2:0] prev_r;
   genvar i;
   always @(posedge ref_clk) begin
      if (srst) begin
         prev_r <= 3'h0;
      end else if (ce) begin
         prev_r <= lvl;
      end
   end
   generate
      for (i = 0; i < 3; i = i + 1) begin : g_ev
         always @(posedge ref_clk) begin
            if (srst) begin
               ev[2*i] <= 1'b0;
               ev[2*i+1] <= 1'b0;
               ev_store[2*i] <= 1'b0;
               ev_store[2*i+1] <= 1'b0;
            end else if (ce) begin
               ev[2*i] <= lvl[i] & ~prev_r[i];
               ev[2*i+1] <= ~lvl[i] & prev_r[i];
               ev_store[2*i] <= lvl[i] & ~prev_r[i] & sel_on[i];
               ev_store[2*i+1] <= ~lvl[i] & prev_r[i] & sel_off[i];
            end
         end
      end
   endgenerate
endmodule

// *** hw/start_guard.v ***
// frequent-start guard: weighted start counter, alarm/inhibit/blocked, events, log
// assumes start pulses from status monitoring and theta from the thermal stage
//
// Behaviour
// - thermal use above hot limit selects hot parameters when separation is on
// - separation works only with thermal stage active; else motor is cold
// - cold safe stall time setting, 0.1 s steps, default 20.0 s
// - unspecified cold stall time falls back to hot stall time
// - hot safe stall time setting, 0.1 s steps, default 15.0 s
// - allowed cold starts per window, default 3
// - allowed hot starts per window, default 2
// - window length in whole hours, default one hour
// - minimum interval between starts, 0.1 s steps, default 20.0 s
// - alarm when exactly one start remains
// - inhibit when all starts used, held until one start is free
// - blocked output while enabled but blocked
// - on and off events for each change of alarm, inhibit, blocked; one per cycle, lowest code wins
// - per event type choose on, off or both for the ev_store flag; the log keeps each cycle's winning event whatever the flag
// - every event carries a time stamp
// - circular log of the latest twelve records
// - record holds time, event, inhibit duration, time since start, count
// - motor data settings are one shared copy
// - outputs routable to direct outputs and user logic
// - each start adds stall time; counter drains by stall time times allowed starts per window
// - modes On, Blocked, Test, Test/Blocked, Off; On after reset
`timescale 1ns/1ps
`include "start_guard_map.vh"
module start_guard #(
   parameter CNT_W = 40,
   parameter TICK_DIV = 2000000,
   parameter TENTHS_PER_HOUR = 36000
) (
   input wire ref_clk,
   input wire srst,
   input wire ce,
   input wire motor_start_detect,
   input wire thermal_overload_stage,
   input wire [9:0] theta_used,
   input wire hot_cold_en,
   input wire [9:0] hot_limit,
   input wire [12:0] stall_cold,
   input wire stall_cold_set,
   input wire [12:0] stall_hot,
   input wire [6:0] starts_cold,
   input wire [6:0] starts_hot,
   input wire [6:0] win_hours,
   input wire [12:0] min_gap,
   input wire mode_wr,
   input wire [2:0] mode_in,
   input wire block_in,
   input wire [2:0] ev_sel_on,
   input wire [2:0] ev_sel_off,
   input wire [`STAMP_W-1:0] time_stamp,
   input wire [3:0] log_rd_idx,
   output reg alarm,
   output reg inhibit,
   output reg blocked,
   output reg [2:0] mode,
   output reg hot_state,
   output reg [6:0] starts_used,
   output reg [6:0] starts_avail,
   output reg ev_valid,
   output reg [2:0] ev_code,
   output reg [`STAMP_W-1:0] ev_stamp,
   output reg ev_store,
   output reg [3:0] log_count,
   output reg [`STAMP_W-1:0] log_rd_stamp,
   output reg [2:0] log_rd_event,
   output reg [`DUR_W-1:0] log_rd_inh_dur,
   output reg [`DUR_W-1:0] log_rd_since,
   output reg [6:0] log_rd_count
);
   // the counter runs in tenth-seconds scaled by TENTHS_PER_HOUR so drain is integer
   reg [CNT_W-1:0] cnt_r;
   reg [CNT_W-1:0] cnt_nxt;
   reg [12:0] gap_r;
   reg gap_act_r;
   reg [`DUR_W-1:0] since_r;
   reg [`DUR_W-1:0] inh_dur_r;
   reg start_d_r;
   wire tick;
   wire [5:0] ev;
   wire [5:0] evs;
   wire run;
   wire hot;
   wire [12:0] stall_sel;
   wire [6:0] nstarts;
   wire [CNT_W-1:0] per_start;
   wire [CNT_W-1:0] cap;
   wire [CNT_W-1:0] drain;
   wire [12:0] cold_eff;
   reg [6:0] used_calc;
   reg [6:0] avail_calc;
   reg alarm_nxt;
   reg inhibit_nxt;
   wire [CNT_W-1:0] per_div;
   wire [CNT_W-1:0] used_div;
   wire [6:0] hours_eff;
   wire blk_mode;
   wire off_mode;
   wire rd_hit;

   // single shared settings copy: these inputs feed every user of motor data
   assign cold_eff = stall_cold_set ? stall_cold : stall_hot;
   assign hot = hot_cold_en & thermal_overload_stage & (theta_used > hot_limit);
   assign stall_sel = hot ? stall_hot : cold_eff;
   assign nstarts = hot ? starts_hot : starts_cold;
   assign per_start = {{(CNT_W-13){1'b0}}, stall_sel} * TENTHS_PER_HOUR;
   assign cap = per_start * {{(CNT_W-7){1'b0}}, nstarts};
   // the full start allowance spread over the window: stall * starts / hours per tenth-second
   assign hours_eff = (win_hours == 7'h0) ? 7'h1 : win_hours;
   assign drain = {{(CNT_W-13){1'b0}}, stall_sel} * {{(CNT_W-7){1'b0}}, nstarts}
      / {{(CNT_W-7){1'b0}}, hours_eff};
   assign run = (mode == `MODE_ON) | (mode == `MODE_TEST);
   assign blk_mode = (mode == `MODE_BLOCKED) | (mode == `MODE_TEST_BLK);
   assign off_mode = (mode == `MODE_OFF);
   // a zero stall setting would divide by zero; the used count is ignored then
   assign per_div = (per_start == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1} : per_start;
   assign used_div = (cnt_r + per_start - {{(CNT_W-1){1'b0}}, 1'b1}) / per_div;
   assign rd_hit = (log_rd_idx < log_count);

   tenth_tick #(
      .DIV(TICK_DIV)
   ) u_tick (
      .ref_clk(ref_clk),
      .srst(srst),
      .ce(ce),
      .tick(tick)
   );

   edge_events u_ev (
      .ref_clk(ref_clk),
      .srst(srst),
      .ce(ce),
      .lvl({blocked, inhibit, alarm}),
      .sel_on(ev_sel_on),
      .sel_off(ev_sel_off),
      .ev(ev),
      .ev_store(evs)
   );

   // codes above Off are dropped so a stray write cannot leave the mode undefined
   always @(posedge ref_clk) begin
      if (srst) begin
         mode <= `MODE_ON;
      end else if (ce && mode_wr && mode_in <= `MODE_OFF) begin
         mode <= mode_in;
      end
   end

   // drain before add, so a start that meets a tick is not lost
   always @* begin
      cnt_nxt = cnt_r;
      if (!run) begin
         cnt_nxt = cnt_r;
      end else begin
         if (tick) begin
            if (cnt_r > drain) begin
               cnt_nxt = cnt_r - drain;
            end else begin
               cnt_nxt = {CNT_W{1'b0}};
            end
         end
         if (start_d_r) begin
            if (cnt_nxt > {CNT_W{1'b1}} - per_start) begin
               cnt_nxt = {CNT_W{1'b1}};
            end else begin
               cnt_nxt = cnt_nxt + per_start;
            end
         end
      end
   end

   always @* begin
      used_calc = 7'h0;
      avail_calc = nstarts;
      if (per_start != {CNT_W{1'b0}}) begin
         if (cnt_r >= cap) begin
            used_calc = nstarts;
         end else begin
            // round up: a partly drained start still counts as used
            used_calc = used_div[6:0];
         end
         avail_calc = nstarts - used_calc;
      end
      alarm_nxt = run & (avail_calc == 7'h1);
      inhibit_nxt = run & ((avail_calc == 7'h0) | gap_act_r);
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         cnt_r <= {CNT_W{1'b0}};
         start_d_r <= 1'b0;
         gap_r <= 13'h0;
         gap_act_r <= 1'b0;
      end else if (ce) begin
         start_d_r <= motor_start_detect & run;
         cnt_r <= cnt_nxt;
         if (start_d_r) begin
            gap_r <= min_gap;
            gap_act_r <= (min_gap != 13'h0);
         end else if (tick) begin
            if (gap_r > 13'h1) begin
               gap_r <= gap_r - 13'h1;
            end else begin
               gap_r <= 13'h0;
               gap_act_r <= 1'b0;
            end
         end
      end
   end

   // elapsed times for the log, in 0.1 s, saturating instead of wrapping
   always @(posedge ref_clk) begin
      if (srst) begin
         since_r <= {`DUR_W{1'b0}};
         inh_dur_r <= {`DUR_W{1'b0}};
      end else if (ce) begin
         if (start_d_r) begin
            since_r <= {`DUR_W{1'b0}};
         end else if (tick && since_r != {`DUR_W{1'b1}}) begin
            since_r <= since_r + 1'b1;
         end
         // cleared as inhibit rises, so an off record still shows the time spent
         if (inhibit_nxt && !inhibit) begin
            inh_dur_r <= {`DUR_W{1'b0}};
         end else if (inhibit && tick && inh_dur_r != {`DUR_W{1'b1}}) begin
            inh_dur_r <= inh_dur_r + 1'b1;
         end
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         alarm <= 1'b0;
         inhibit <= 1'b0;
         blocked <= 1'b0;
         hot_state <= 1'b0;
         starts_used <= 7'h0;
         starts_avail <= 7'h0;
      end else if (ce) begin
         alarm <= alarm_nxt;
         inhibit <= inhibit_nxt;
         blocked <= blk_mode | (block_in & ~off_mode);
         hot_state <= hot;
         starts_used <= used_calc;
         starts_avail <= avail_calc;
      end
   end

   // event output: lowest pending index wins; alarm and inhibit edges often meet
   // since both levels change from one counter; the losing edge is dropped, a trade kept for size
   reg [2:0] pick;
   reg any_ev;
   integer k;
   always @* begin
      pick = 3'h0;
      any_ev = 1'b0;
      for (k = 5; k >= 0; k = k - 1) begin
         if (ev[k]) begin
            pick = k[2:0];
            any_ev = 1'b1;
         end
      end
   end

   // log memory
   reg [`STAMP_W-1:0] lg_stamp [0:`LOG_DEPTH-1];
   reg [2:0] lg_event [0:`LOG_DEPTH-1];
   reg [`DUR_W-1:0] lg_inh [0:`LOG_DEPTH-1];
   reg [`DUR_W-1:0] lg_since [0:`LOG_DEPTH-1];
   reg [6:0] lg_count [0:`LOG_DEPTH-1];
   reg [`LOG_PTR_W-1:0] wr_ptr_r;

   always @(posedge ref_clk) begin
      if (srst) begin
         ev_valid <= 1'b0;
         ev_code <= 3'h0;
         ev_stamp <= {`STAMP_W{1'b0}};
         ev_store <= 1'b0;
         wr_ptr_r <= {`LOG_PTR_W{1'b0}};
         log_count <= 4'h0;
      end else if (ce) begin
         ev_valid <= any_ev;
         ev_store <= any_ev & evs[pick];
         if (any_ev) begin
            ev_code <= pick;
            ev_stamp <= time_stamp;
            if (wr_ptr_r == `LOG_LAST) begin
               wr_ptr_r <= {`LOG_PTR_W{1'b0}};
            end else begin
               wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (log_count != `LOG_DEPTH) begin
               log_count <= log_count + 4'h1;
            end
         end
      end
   end

   // the record store has no reset: rd_hit keeps unwritten entries unseen
   always @(posedge ref_clk) begin
      if (ce && !srst && any_ev) begin
         lg_stamp[wr_ptr_r] <= time_stamp;
         lg_event[wr_ptr_r] <= pick;
         lg_inh[wr_ptr_r] <= inh_dur_r;
         lg_since[wr_ptr_r] <= since_r;
         lg_count[wr_ptr_r] <= starts_used;
      end
   end

   // read port: index 0 is the newest record
   // the four-bit wrap is safe because rd_hit rejects indices past the filled entries
   reg [`LOG_PTR_W-1:0] rd_slot;
   always @* begin
      if (log_rd_idx >= wr_ptr_r) begin
         rd_slot = wr_ptr_r + `LOG_LAST - log_rd_idx;
      end else begin
         rd_slot = wr_ptr_r - 4'h1 - log_rd_idx;
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         log_rd_stamp <= {`STAMP_W{1'b0}};
         log_rd_event <= 3'h0;
         log_rd_inh_dur <= {`DUR_W{1'b0}};
         log_rd_since <= {`DUR_W{1'b0}};
         log_rd_count <= 7'h0;
      end else if (ce) begin
         if (rd_hit) begin
            log_rd_stamp <= lg_stamp[rd_slot];
            log_rd_event <= lg_event[rd_slot];
            log_rd_inh_dur <= lg_inh[rd_slot];
            log_rd_since <= lg_since[rd_slot];
            log_rd_count <= lg_count[rd_slot];
         end else begin
            log_rd_stamp <= {`STAMP_W{1'b0}};
            log_rd_event <= 3'h0;
            log_rd_inh_dur <= {`DUR_W{1'b0}};
            log_rd_since <= {`DUR_W{1'b0}};
            log_rd_count <= 7'h0;
         end
      end
   end
endmodule

// *** hw/start_guard_map.vh ***
// constants for the frequent-start guard: settings, encodings, log layout
// assumes a program cycle of one ref_clk tick gated by the clock enable
`ifndef START_GUARD_MAP_VH
`define START_GUARD_MAP_VH

`define HOT_LIMIT_DEF 10'h2BC
`define STALL_COLD_DEF 13'h00C8
`define STALL_HOT_DEF 13'h0096
`define STARTS_COLD_DEF 7'h03
`define STARTS_HOT_DEF 7'h02
`define WIN_HOURS_DEF 7'h01
`define MIN_GAP_DEF 13'h00C8

`define CLK_HZ 32'h01312D00
`define TENTH_S_NUM 32'h0000000A
`define SEC_PER_HOUR 32'h00000E10

`define MODE_ON 3'h0
`define MODE_BLOCKED 3'h1
`define MODE_TEST 3'h2
`define MODE_TEST_BLK 3'h3
`define MODE_OFF 3'h4

`define EV_ALARM_ON 3'h0
`define EV_ALARM_OFF 3'h1
`define EV_INH_ON 3'h2
`define EV_INH_OFF 3'h3
`define EV_BLK_ON 3'h4
`define EV_BLK_OFF 3'h5

`define LOG_DEPTH 12
`define LOG_PTR_W 4
`define LOG_LAST 4'hB
`define STAMP_W 48
`define DUR_W 32

`endif

// *** hw/tenth_tick.v ***
// divides the enabled clock into one pulse per 0.1 s
// assumes ref_clk at the rate in the map header
`timescale 1ns/1ps
`include "start_guard_map.vh"
module tenth_tick #(
   parameter DIV = 2000000
) (
   input wire ref_clk,
   input wire srst,
   input wire ce,
   output reg tick
);
   reg [31:0] cnt_r;
   always @(posedge ref_clk) begin
      if (srst) begin
         cnt_r <= 32'h0;
         tick <= 1'b0;
      end else if (ce) begin
         if (cnt_r >= DIV - 1) begin
            cnt_r <= 32'h0;
            tick <= 1'b1;
         end else begin
            cnt_r <= cnt_r + 32'h1;
            tick <= 1'b0;
         end
      end
   end
endmodule
